// ---- trs_pkg.sv ----
// Purpose: Shared constants and types for the triple regulator sequencer.
// Assumes: 10 MHz system clock, classic Wishbone slave with 32-bit data.
// Notes: Offsets are byte addresses of aligned 32-bit words.
package trs_pkg;
  // Number of regulator channels.
  localparam int TRS_NCH = 3;
  // Clock rate in hertz.
  localparam longint TRS_CLK_HZ = 10000000;
  // Good delay time at default setting, in microseconds.
  localparam longint TRS_GOOD_DELAY_US = 115000;
  // Delay cycles derived from the time and the clock rate.
  localparam int TRS_GOOD_DELAY_CYC =
    int'(TRS_GOOD_DELAY_US * TRS_CLK_HZ / 1000000);
  // Delay slope in seconds per farad, times 1000.
  localparam int TRS_DELAY_S_PER_F_X1000 = 213100000;
  // Soft-start time in microseconds.
  localparam longint TRS_SOFT_START_US = 1000;
  // Soft-start cycles derived from time and clock rate.
  localparam int TRS_SOFT_START_CYC =
    int'(TRS_SOFT_START_US * TRS_CLK_HZ / 1000000);
  // Reference nominal value in millivolts, reached at ramp end.
  localparam logic [11:0] TRS_REF_NOM_MV = 12'h320;
  // Register offsets.
  localparam logic [7:0] TRS_OFS_CTRL = 8'h00;
  localparam logic [7:0] TRS_OFS_STAT = 8'h04;
  localparam logic [7:0] TRS_OFS_DELAY = 8'h08;
  // Control register field positions.
  localparam int TRS_CTRL_EXTSUP_BIT = 0;
  // Reset values.
  localparam logic [31:0] TRS_DELAY_RST = 32'h00118C30;
  localparam logic [0:0] TRS_CTRL_RST = 1'h0;
  // Channel state codes.
  typedef enum logic [2:0]
  {
    CH_OFF = 3'b001,
    CH_RAMP = 3'b010,
    CH_RUN = 3'b100
  } trs_ch_state_t;
  // Monitor comparator group carried together.
  typedef struct packed
  {
    logic thermal;
    logic uv_int;
    logic uv_ext;
    logic startup;
    logic cp_ok;
    logic bias_ok;
    logic warn;
  } trs_mon_t;
endpackage

// ---- trs_sequencer.sv ----
// Purpose: Channel start/stop sequencing and supply good flag timing.
// Assumes: All comparator and enable inputs are asynchronous levels.
// Notes: Behaviour
// Behaviour
// - Each channel enabled independently.
// - Soft start needs enable, supplies, no thermal.
// - Overload never restarts soft start.
// - Reference ramps linearly zero to nominal.
// - Thermal or input undervoltage disables all.
// - Fault clear restarts enabled channels freshly.
// - Shutdown threshold chosen by supply config.
// - Power-up uses internal threshold until external.
// - Tied enables start all channels together.
// - Delay timer starts after all 85%.
// - Flag rises only if all above 80%.
// - New enable clears flag, requalifies.
// - Disabled channels ignored for flag.
// - Below 80% clears flag; 85% restarts timer.
// - Feedback drop alone causes no soft start.
// - Last channel disabled clears flag.
// - Input warning clears flag, switchers run.
// - Warning clear guaranteed with external supply.
// - Delay length configurable, linear scaling.
// - Enables are active high.
`timescale 1ns/1ps
`default_nettype none
module trs_sequencer
  import trs_pkg::*;
#(
  parameter int NCH = TRS_NCH,
  parameter int SS_CYC = TRS_SOFT_START_CYC
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [NCH-1:0] channel_enable_i,
  input wire logic [NCH-1:0] fb_above_85_i,
  input wire logic [NCH-1:0] fb_above_80_i,
  input wire trs_mon_t mon_i,
  input wire logic ext_supply_present_i,
  output logic [NCH-1:0] channel_run_o,
  output logic [NCH*12-1:0] ref_level_o,
  output logic supply_good_flag_o,
  output logic charge_pump_run_o,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  output logic err_o
);
  // Synchroniser width: enables, two feedback groups, monitors, ext supply.
  localparam int SW = 3*NCH + 8;
  // First and second stages of the input synchroniser.
  logic [SW-1:0] sync1_ff;
  logic [SW-1:0] sync2_ff;
  // Synchronised views of the inputs.
  logic [NCH-1:0] en_s;
  logic [NCH-1:0] f85_s;
  logic [NCH-1:0] f80_s;
  trs_mon_t mon_s;
  logic ext_s;
  // Previous enables, to find rising edges.
  logic [NCH-1:0] en_prev_ff;
  // Per-channel state and ramp counters.
  trs_ch_state_t st_ff [NCH];
  logic [31:0] ramp_ff [NCH];
  // Supply configuration latched by software or the external flag.
  logic ext_cfg_ff;
  // Power-up latch: stays low until the startup threshold is first met.
  logic started_ff;
  // Delay setting in cycles and running delay counter.
  logic [31:0] delay_ff;
  logic [31:0] cnt_ff;
  logic timing_ff;
  // Combined shutdown and start conditions.
  logic shutdown;
  logic start_ok;
  logic any_en;
  logic all85;
  logic all80;
  logic new_en;

  // Scale a cycle fraction into a reference level in millivolts.
  function automatic logic [11:0] ramp_mv(input logic [31:0] c);
    logic [43:0] p;
    p = {12'h000, c} * {32'h0, TRS_REF_NOM_MV};
    ramp_mv = 12'(p / 44'(SS_CYC));
  endfunction

  // Two flip-flop synchroniser on every asynchronous input.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end
    else
    begin
      sync1_ff <= {ext_supply_present_i, mon_i, fb_above_80_i, fb_above_85_i,
                   channel_enable_i};
      sync2_ff <= sync1_ff;
    end
  end

  // Unpack the synchronised bus.
  always_comb
  begin
    en_s = sync2_ff[NCH-1:0];
    f85_s = sync2_ff[2*NCH-1:NCH];
    f80_s = sync2_ff[3*NCH-1:2*NCH];
    mon_s = sync2_ff[3*NCH+6:3*NCH];
    ext_s = sync2_ff[SW-1];
  end

  // Fault and start qualification.
  always_comb
  begin
    // Threshold follows supply config; before start only the internal one.
    shutdown = mon_s.thermal ||
               ((ext_cfg_ff && started_ff) ? mon_s.uv_ext : mon_s.uv_int)
               || !started_ff;
    start_ok = !shutdown && mon_s.cp_ok && mon_s.bias_ok;
    any_en = |en_s;
    all85 = &(f85_s | ~en_s);
    all80 = &(f80_s | ~en_s);
    new_en = |(en_s & ~en_prev_ff);
  end

  // Power-up latch and supply configuration.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      started_ff <= 1'b0;
      ext_cfg_ff <= TRS_CTRL_RST;
    end
    else
    begin
      // Startup threshold arms; an internal undervoltage re-disarms unless the external supply config is set.
      if (mon_s.startup)
        started_ff <= 1'b1;
      else if (mon_s.uv_int && !ext_cfg_ff)
        started_ff <= 1'b0;
      // External supply detection lowers the shutdown threshold.
      if (cyc_i && stb_i && we_i && !ack_o && adr_i == TRS_OFS_CTRL && sel_i[0])
        ext_cfg_ff <= dat_i[TRS_CTRL_EXTSUP_BIT];
      else if (ext_s)
        ext_cfg_ff <= 1'b1;
    end
  end

  // Per-channel state machine: off, ramp, run.
  for (genvar i = 0; i < NCH; i++)
  begin : g_ch
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        st_ff[i] <= CH_OFF;
        ramp_ff[i] <= 32'h0;
      end
      else
      begin
        unique case (st_ff[i])
          CH_OFF:
          begin
            // Fresh ramp from zero on every start.
            ramp_ff[i] <= 32'h0;
            if (en_s[i] && start_ok)
              st_ff[i] <= CH_RAMP;
          end
          CH_RAMP:
          begin
            if (!en_s[i] || shutdown)
              st_ff[i] <= CH_OFF;
            else if (ramp_ff[i] >= 32'(SS_CYC))
              st_ff[i] <= CH_RUN;
            else
              ramp_ff[i] <= ramp_ff[i] + 32'h1;
          end
          CH_RUN:
          begin
            // Feedback loss does not leave run; only faults or disable.
            if (!en_s[i] || shutdown)
              st_ff[i] <= CH_OFF;
          end
          default:
            st_ff[i] <= CH_OFF;
        endcase
      end
    end
  end

  // Registered channel outputs and reference levels.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      channel_run_o <= '0;
      ref_level_o <= '0;
      charge_pump_run_o <= 1'b0;
      en_prev_ff <= '0;
    end
    else
    begin
      en_prev_ff <= en_s;
      charge_pump_run_o <= started_ff && !mon_s.thermal;
      for (int i = 0; i < NCH; i++)
      begin
        channel_run_o[i] <= (st_ff[i] != CH_OFF);
        ref_level_o[i*12 +: 12] <= (st_ff[i] == CH_RUN) ? TRS_REF_NOM_MV :
          (st_ff[i] == CH_RAMP) ? ramp_mv(ramp_ff[i]) : 12'h000;
      end
    end
  end

  // Delay timer and supply good flag.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      supply_good_flag_o <= 1'b0;
      timing_ff <= 1'b0;
      cnt_ff <= 32'h0;
    end
    else if (!any_en || new_en || mon_s.warn || shutdown)
    begin
      // Last disable, new enable, input warning or fault drops the flag.
      supply_good_flag_o <= 1'b0;
      timing_ff <= 1'b0;
      cnt_ff <= 32'h0;
    end
    else if (supply_good_flag_o)
    begin
      if (!all80)
        supply_good_flag_o <= 1'b0;
    end
    else if (!timing_ff)
    begin
      // Timer starts once every enabled channel is at 85%.
      if (all85)
        timing_ff <= 1'b1;
      cnt_ff <= 32'h0;
    end
    else if (!all80)
      timing_ff <= 1'b0;
    else if (cnt_ff + 32'h1 >= delay_ff)
    begin
      timing_ff <= 1'b0;
      supply_good_flag_o <= 1'b1;
    end
    else
      cnt_ff <= cnt_ff + 32'h1;
  end

  // Wishbone slave: one wait-free ack, error on unmapped offsets.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h0;
      delay_ff <= TRS_DELAY_RST;
    end
    else
    begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      if (cyc_i && stb_i && !ack_o && !err_o)
      begin
        unique case (adr_i)
          TRS_OFS_CTRL:
          begin
            ack_o <= 1'b1;
            dat_o <= {31'h0, ext_cfg_ff};
          end
          TRS_OFS_STAT:
          begin
            ack_o <= 1'b1;
            dat_o <= {24'h0, started_ff, supply_good_flag_o, timing_ff,
                      shutdown, 1'b0, channel_run_o};
          end
          TRS_OFS_DELAY:
          begin
            ack_o <= 1'b1;
            dat_o <= delay_ff;
            // Delay length in cycles, written byte by byte.
            if (we_i)
              for (int b = 0; b < 4; b++)
                if (sel_i[b])
                  delay_ff[b*8 +: 8] <= dat_i[b*8 +: 8];
          end
          default:
          begin
            err_o <= 1'b1;
            dat_o <= 32'h0;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ---- trs_seq_monitor.sv ----
// Purpose: Port-level checks for the sequencer.
// Assumes: Inputs cross a two-flop synchroniser.
// Notes: Level checks wait four cycles for that delay, the thermal check five.
`timescale 1ns/1ps
`default_nettype none
module trs_seq_monitor
  import trs_pkg::*;
#(
  parameter int NCH = TRS_NCH,
  parameter int SS_CYC = TRS_SOFT_START_CYC
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [NCH-1:0] channel_enable_i,
  input wire logic [NCH-1:0] fb_above_85_i,
  input wire logic [NCH-1:0] fb_above_80_i,
  input wire trs_mon_t mon_i,
  input wire logic ext_supply_present_i,
  input wire logic [NCH-1:0] channel_run_o,
  input wire logic [NCH*12-1:0] ref_level_o,
  input wire logic supply_good_flag_o,
  input wire logic charge_pump_run_o,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic err_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // A new bus request with no answer pending.
  wire logic req_new = cyc_i && stb_i && !ack_o && !err_o;
  // Channels that are on but whose feedback sits below the low level.
  wire logic [NCH-1:0] low_fb = channel_enable_i & ~fb_above_80_i;
  ack_one_a: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  bus_answer_a: assert property (req_new |=> ack_o || err_o)
    else $error("bus request not answered next cycle");
  bad_addr_a: assert property (req_new && adr_i > 8'h08 |=> err_o && !ack_o)
    else $error("unmapped access not refused");
  flag_reset_a: assert property ($fell(rst_i) |-> !supply_good_flag_o)
    else $error("flag high right after reset");
  // Two sync stages, the state register and the output register, then one sample: five.
  thermal_off_a: assert property (mon_i.thermal [*5] |-> !channel_run_o)
    else $error("channel runs during thermal shutdown");
  low_fb_a: assert property (low_fb != 0 [*4] |-> !supply_good_flag_o)
    else $error("flag high with feedback low");
  none_en_a: assert property (!channel_enable_i [*4] |-> !supply_good_flag_o)
    else $error("flag high with no channel enabled");
  warn_clr_a: assert property (mon_i.warn [*4] |-> !supply_good_flag_o)
    else $error("flag high below warning level");
  ref_top_a: assert property (ref_level_o[11:0] <= 12'h320)
    else $error("reference above nominal");
  cover property ($rose(supply_good_flag_o));
  cover property (err_o);
  cover property (mon_i.thermal && channel_enable_i != 0);
endmodule
bind trs_sequencer trs_seq_monitor #(.NCH(NCH), .SS_CYC(SS_CYC)) mon_inst (.*);
`default_nettype wire

// ---- trs_ctrl_model.sv ----
// Purpose: System controller that watches the supply good flag.
// Assumes: Flag is a registered level.
// Notes: Counts rises so the bench can spot a flag that toggles.
`timescale 1ns/1ps
`default_nettype none
module trs_ctrl_model
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic flag_i,
  output var int rises_o
);
  // Previous flag value.
  logic last_ff;
  // Tally each rise; a delay longer than start-up gives one.
  always_ff @(posedge clk_i)
  begin
    last_ff <= flag_i;
    if (rst_i)
      rises_o <= 0;
    else if (flag_i && !last_ff)
      rises_o <= rises_o + 1;
  end
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Purpose: Self-checking bench for the sequencer.
// Assumes: Short soft start and short good delay.
// Notes: Rows hold input levels and the levels they should give.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import trs_pkg::*;
  // One row: enables, fb levels, monitor word, expected run and flag.
  typedef struct packed
  {
    logic [2:0] en;
    logic [2:0] f85;
    logic [2:0] f80;
    logic [6:0] mon;
    logic [2:0] run;
    logic flag;
  } trs_row_t;
  localparam int DLY = 20;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [2:0] en = 3'h0;
  logic [2:0] f85 = 3'h0;
  logic [2:0] f80 = 3'h0;
  trs_mon_t mon = '0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic [2:0] run;
  logic [35:0] ref_lv;
  logic [31:0] rdat;
  logic [31:0] rd;
  logic flag;
  logic ack;
  logic err;
  logic e;
  int err_total = 0;
  int n_tests = 0;
  int rises;
  int r0;
  // Rows in order: all, ch1 off, new ch1, thermal, restart, undervolt,
  // warning, ch0 low, none enabled.
  trs_row_t rows [9] = '{
    '{3'h7, 3'h7, 3'h7, 7'h0E, 3'h7, 1'b1},
    '{3'h5, 3'h5, 3'h5, 7'h0E, 3'h5, 1'b1},
    '{3'h3, 3'h1, 3'h3, 7'h0E, 3'h3, 1'b0},
    '{3'h7, 3'h7, 3'h7, 7'h4E, 3'h0, 1'b0},
    '{3'h7, 3'h7, 3'h7, 7'h0E, 3'h7, 1'b1},
    '{3'h7, 3'h7, 3'h7, 7'h2E, 3'h0, 1'b0},
    '{3'h7, 3'h7, 3'h7, 7'h0F, 3'h7, 1'b0},
    '{3'h7, 3'h6, 3'h6, 7'h0E, 3'h7, 1'b0},
    '{3'h0, 3'h7, 3'h7, 7'h0E, 3'h0, 1'b0}};
  trs_sequencer #(.SS_CYC(16)) trs_sequencer_inst (
    .clk_i(clk_i), .rst_i(rst_i), .channel_enable_i(en),
    .fb_above_85_i(f85), .fb_above_80_i(f80), .mon_i(mon),
    .ext_supply_present_i(1'b0), .channel_run_o(run),
    .ref_level_o(ref_lv), .supply_good_flag_o(flag),
    .charge_pump_run_o(), .adr_i(adr), .dat_i(dat), .dat_o(rdat),
    .we_i(we), .sel_i(4'hF), .cyc_i(cyc), .stb_i(stb), .ack_o(ack),
    .err_o(err));
  trs_ctrl_model trs_ctrl_model_inst (.clk_i(clk_i), .rst_i(rst_i),
    .flag_i(flag), .rises_o(rises));
  // Clock at 10 MHz.
  always #50 clk_i = ~clk_i;
  // Compare and count; report a mismatch at once.
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
      err_total++;
    end
  endtask
  // Print counts and verdict, then end the run.
  task automatic test_done;
    $display("checks=%0d errors=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // One classic Wishbone cycle, held until ack or err is sampled.
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (!(ack || err) && n < 20);
    rd = rdat;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 20)
    begin
      err_total++;
      test_done;
    end
  endtask
  // Main sequence: reset, registers, rows, then the delay timing.
  initial
  begin
    repeat (4) @(posedge clk_i);
    chk({28'h0, run, flag}, 32'h0);
    @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h08, 32'h0);
    chk(rd, TRS_DELAY_RST);
    wb(1'b0, 8'h00, 32'h0);
    chk(rd, {31'h0, TRS_CTRL_RST});
    wb(1'b1, 8'h08, DLY);
    wb(1'b0, 8'h08, 32'h0);
    chk(rd, DLY);
    wb(1'b0, 8'h0C, 32'h0);
    chk({31'h0, e}, 32'h1);
    foreach (rows[i])
    begin
      en <= rows[i].en;
      f85 <= rows[i].f85;
      f80 <= rows[i].f80;
      mon <= rows[i].mon;
      repeat (60) @(posedge clk_i);
      chk({28'h0, run, flag}, {28'h0, rows[i].run, rows[i].flag});
      for (int c = 0; c < 3; c++)
        if (rows[i].run[c])
          chk({20'h0, ref_lv[12*c+:12]}, 32'h320);
    end
    r0 = rises;
    en <= 3'h7;
    repeat (DLY) @(posedge clk_i);
    chk({31'h0, flag}, 32'h0);
    repeat (40) @(posedge clk_i);
    chk({31'h0, flag}, 32'h1);
    chk(rises, r0 + 1);
    // Controller drops and raises channel 0 to force a fresh soft start.
    en <= 3'h6;
    repeat (5) @(posedge clk_i);
    en <= 3'h7;
    repeat (6) @(posedge clk_i);
    chk({31'h0, run[0]}, 32'h1);
    chk({31'h0, ref_lv[11:0] < 12'h320}, 32'h1);
    // External supply config: the higher threshold alone no longer trips.
    wb(1'b1, 8'h00, 32'h1);
    mon <= 7'h2E;
    repeat (10) @(posedge clk_i);
    chk({29'h0, run}, 32'h7);
    // Reset again in mid-run, before the flag has risen: it must read low after two cycles.
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk({31'h0, flag}, 32'h0);
    rst_i <= 1'b0;
    test_done;
  end
endmodule
`default_nettype wire
